/* File: hw/hostcfg_pkg.sv */
// Package with offsets, field positions, reset values and timing for the host configuration bank.
package hostcfg_pkg;

  // Halfword register offsets on the host bus.
  localparam logic [7:0] OFS_BUS_ERR = 8'h06;
  localparam logic [7:0] OFS_CHIP_CFG = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO = 8'h10;
  localparam logic [7:0] OFS_ADDR_MID = 8'h12;
  localparam logic [7:0] OFS_ADDR_HI = 8'h14;
  localparam logic [7:0] OFS_BUS_CTRL = 8'h20;
  localparam logic [7:0] OFS_ROM_CTRL = 8'h22;

  // Field positions.
  localparam int BIT_LANE_FLAG = 15;
  localparam int BIT_PAT_HI = 14;
  localparam int BIT_PAT_LO = 11;
  localparam int BIT_ENDIAN = 10;
  localparam int BIT_ROM_PRESENT = 9;
  localparam int BIT_BYTE_BUS = 7;
  localparam int BIT_HALF_BUS = 6;
  localparam int BIT_WORD_BUS = 5;
  localparam int BIT_PKG128 = 3;
  localparam int BIT_DRIVE = 6;
  localparam int BIT_CLK_SEL = 2;
  localparam int BIT_CLK_DIV_HI = 1;
  localparam int BIT_SW_ACCESS = 4;
  localparam int BIT_ROM_DI = 3;
  localparam int BIT_PIN_DO = 2;
  localparam int BIT_PIN_SK = 1;
  localparam int BIT_PIN_CS = 0;
  localparam int BIT_CFG_BYTE = 0;
  localparam int BIT_CFG_HALF = 1;

  // Values after reset.
  localparam logic [15:0] BUS_CTRL_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [2:0] ROM_PINS_RST = 3'h0;

  // Bonding options of this variant.
  localparam logic BOND_WORD_BUS = 1'b1;
  localparam logic BOND_PKG128 = 1'b1;

  // Serial ROM layout and command framing.
  localparam logic [5:0] ROM_CFG_WORD = 6'h00;
  localparam logic [1:0] ROM_LAST_IDX = 2'h3;
  localparam logic [2:0] ROM_READ_OP = 3'h6;
  localparam logic [4:0] ROM_CMD_BITS = 5'h09;
  localparam logic [4:0] ROM_FRAME_BITS = 5'h1a;

  // Timing at the 50 ns system clock.
  localparam int CLK_PERIOD_NS = 50;
  localparam int ROM_SK_HALF_NS = 500;
  localparam logic [4:0] ROM_SK_HALF_CYC = 5'((ROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // The third synchroniser stage and the agreement flop need four edges after release; take the straps at the fifth.
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h5;

  typedef enum logic [3:0] {
    LD_IDLE = 4'h1,
    LD_RUN = 4'h2,
    LD_GAP = 4'h4,
    LD_DONE = 4'h8
  } ld_state_t;

endpackage : hostcfg_pkg

/* File: hw/rom_loader.sv */
// Serial ROM reader that fetches the configuration word and the three station address words after reset.
`timescale 1ns/1ps
module rom_loader
  import hostcfg_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic i_rom_di,
  // Serial pins
  output logic o_cs,
  output logic o_sk,
  output logic o_do,
  // Fetched words
  output logic [15:0] o_word,
  output logic [1:0] o_word_idx,
  output logic o_word_valid,
  output logic o_done
);

  ld_state_t state_q;
  logic [4:0] div_q;
  logic [4:0] bit_q;
  logic [1:0] idx_q;
  logic [15:0] shift_q;
  logic cs_q;
  logic sk_q;
  logic valid_q;
  logic done_q;

  wire half_tick = (div_q == ROM_SK_HALF_CYC - 5'h01);
  wire last_bit = (bit_q == ROM_FRAME_BITS - 5'h01);
  wire [8:0] cmd = {ROM_READ_OP, ROM_CFG_WORD + {4'h0, idx_q}};
  wire [8:0] cmd_sh = cmd >> (ROM_CMD_BITS - 5'h01 - bit_q);
  // The data bits start one clock after the command, behind a dummy zero.
  wire in_data = (bit_q > ROM_CMD_BITS);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= LD_IDLE;
      div_q <= 5'h00;
      bit_q <= 5'h00;
      idx_q <= 2'h0;
      shift_q <= 16'h0000;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      valid_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      div_q <= half_tick ? 5'h00 : div_q + 5'h01;
      case (state_q)
        LD_IDLE: begin
          div_q <= 5'h00;
          if (i_start) begin
            state_q <= LD_RUN;
            cs_q <= 1'b1;
            bit_q <= 5'h00;
          end
        end
        LD_RUN: begin
          if (half_tick) begin
            sk_q <= ~sk_q;
            if (!sk_q) begin
              if (in_data) begin
                shift_q <= {shift_q[14:0], i_rom_di};
              end
            end else if (last_bit) begin
              state_q <= LD_GAP;
              cs_q <= 1'b0;
              valid_q <= 1'b1;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end
        end
        LD_GAP: begin
          if (half_tick) begin
            if (idx_q == ROM_LAST_IDX) begin
              state_q <= LD_DONE;
              done_q <= 1'b1;
            end else begin
              idx_q <= idx_q + 2'h1;
              bit_q <= 5'h00;
              cs_q <= 1'b1;
              state_q <= LD_RUN;
            end
          end
        end
        LD_DONE: begin
          done_q <= 1'b1;
        end
        default: begin
          state_q <= LD_IDLE;
        end
      endcase
    end
  end

  assign o_cs = cs_q;
  assign o_sk = sk_q;
  assign o_do = cs_q & (bit_q < ROM_CMD_BITS) & cmd_sh[0];
  assign o_word = shift_q;
  assign o_word_idx = idx_q;
  assign o_word_valid = valid_q;
  assign o_done = done_q;

endmodule : rom_loader

/* File: hw/hostcfg_regs.sv */
// Host-visible global configuration register bank with strap capture and serial ROM pin control.
// Overview of operation
// - A forbidden byte-lane combination sets bit 15; host writing one clears it.
// - Offending lane pattern captured in bits 14..11, lane 3 highest, valid with flag.
// - Endianness strap latched at reset into read-only bit 10, one is little-endian.
// - Serial ROM presence strap latched at reset into read-only bit 9.
// - Bit 7 reports byte-wide bus, from ROM or from data-input strap.
// - Bit 6 reports halfword-wide bus, from ROM or from data-input strap.
// - Bit 5 reads one for the word-wide bus variant.
// - Bit 3 reads one for the 128-pin package.
// - With ROM present, station address loads from ROM words starting at word one.
// - ROM words one, two, three fill low, middle and high address registers.
// - Host access to address registers never touches the ROM contents.
// - Bus control bit 6 selects pad drive, 8 mA at zero, resets zero.
// - Bus control bit 2 selects bus clock source, zero is 125MHz, resets zero.
// - Bus control bits 1..0 pick divide by one, two or three; resets 00.
// - ROM control bit 4 hands the serial pins to software through bits 2..0.
// - ROM control bit 3 reads the live data-input pin level.
// - Bits 2, 1, 0 drive data-out, serial clock, chip select; reset zero.
`timescale 1ns/1ps
module hostcfg_regs
  import hostcfg_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Host register port
  input wire logic i_bus_sel,
  input wire logic i_bus_rd,
  input wire logic i_bus_wr,
  input wire logic [7:0] i_bus_addr,
  input wire logic [3:0] i_bus_be,
  input wire logic [31:0] i_bus_wdata,
  output logic [31:0] o_bus_rdata,
  output logic o_bus_rvalid,
  // Straps and serial ROM pins
  input wire logic i_rom_present_strap,
  input wire logic i_rom_data_input_pin,
  input wire logic i_rom_serial_clock_pin,
  output logic o_rom_serial_clock_pin,
  output logic o_rom_serial_clock_oe,
  output logic o_rom_data_output_pin,
  output logic o_rom_chip_select_pin,
  // Chip-level controls
  output logic o_pad_drive_strong,
  output logic o_bus_clk_sel,
  output logic [1:0] o_bus_clk_div,
  output logic o_config_loaded
);

  localparam int PIN_PRESENT = 0;
  localparam int PIN_DI = 1;
  localparam int PIN_SK = 2;

  // Pin synchronisers: three stages, a rise is accepted when stages two and three agree, a fall as soon as stage two falls.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_q;
  wire [2:0] pins_raw = {i_rom_serial_clock_pin, i_rom_data_input_pin, i_rom_present_strap};

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (sync2_q & sync3_q) | (pin_q & ~(sync2_q ^ sync3_q));
    end
  end

  // Strap capture a few cycles after reset release, once the synchronisers hold real pin levels.
  logic [2:0] settle_q;
  logic strap_done_q;
  logic endian_q;
  logic present_q;
  logic byte_bus_q;
  logic half_bus_q;
  logic ld_start_q;
  logic load_done_q;
  wire strap_take = !strap_done_q && (settle_q == STRAP_SETTLE_CYC - 3'h1);

  // Loader connections.
  logic ld_cs;
  logic ld_sk;
  logic ld_do;
  logic [15:0] ld_word;
  logic [1:0] ld_idx;
  logic ld_valid;
  logic ld_done;

  rom_loader u_loader (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_start(ld_start_q),
    .i_rom_di(pin_q[PIN_DI]),
    .o_cs(ld_cs),
    .o_sk(ld_sk),
    .o_do(ld_do),
    .o_word(ld_word),
    .o_word_idx(ld_idx),
    .o_word_valid(ld_valid),
    .o_done(ld_done)
  );

  wire cfg_word_in = ld_valid && (ld_idx == 2'h0);
  wire addr_lo_in = ld_valid && (ld_idx == 2'h1);
  wire addr_mid_in = ld_valid && (ld_idx == 2'h2);
  wire addr_hi_in = ld_valid && (ld_idx == 2'h3);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      settle_q <= 3'h0;
      strap_done_q <= 1'b0;
      endian_q <= 1'b0;
      present_q <= 1'b0;
      byte_bus_q <= 1'b0;
      half_bus_q <= 1'b0;
      ld_start_q <= 1'b0;
      load_done_q <= 1'b0;
    end else begin
      ld_start_q <= strap_take & pin_q[PIN_PRESENT];
      if (!strap_done_q) begin
        settle_q <= settle_q + 3'h1;
      end
      if (strap_take) begin
        strap_done_q <= 1'b1;
        endian_q <= pin_q[PIN_SK];
        present_q <= pin_q[PIN_PRESENT];
        byte_bus_q <= ~pin_q[PIN_DI];
        half_bus_q <= pin_q[PIN_DI];
      end else if (cfg_word_in) begin
        byte_bus_q <= ld_word[BIT_CFG_BYTE];
        half_bus_q <= ld_word[BIT_CFG_HALF];
      end
      if (strap_done_q && (!present_q || ld_done)) begin
        load_done_q <= 1'b1;
      end
    end
  end

  // Host bus decode. Legal lane sets are one byte, either halfword or the whole word.
  wire bus_req = i_bus_sel & (i_bus_rd | i_bus_wr);
  wire lanes_legal = (i_bus_be == 4'h1) || (i_bus_be == 4'h2) || (i_bus_be == 4'h4) || (i_bus_be == 4'h8) ||
                     (i_bus_be == 4'h3) || (i_bus_be == 4'hc) || (i_bus_be == 4'hf);
  wire bad_access = bus_req & ~lanes_legal;
  // A write with a forbidden lane set is dropped so no register takes a torn value.
  wire wr_ok = i_bus_sel & i_bus_wr & lanes_legal;
  wire rd_ok = i_bus_sel & i_bus_rd;

  function automatic logic lane_hit(input logic [7:0] off, input logic lane);
    lane_hit = wr_ok && (i_bus_addr[7:2] == off[7:2]) && i_bus_be[{off[1], lane}];
  endfunction : lane_hit

  function automatic logic [15:0] half_data(input logic [7:0] off);
    half_data = off[1] ? i_bus_wdata[31:16] : i_bus_wdata[15:0];
  endfunction : half_data

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [7:0] off);
    logic [15:0] nv;
    nv = half_data(off);
    merge = {lane_hit(off, 1'b1) ? nv[15:8] : old[15:8], lane_hit(off, 1'b0) ? nv[7:0] : old[7:0]};
  endfunction : merge

  // Register state.
  logic lane_flag_q;
  logic [3:0] lane_pat_q;
  logic [15:0] addr_lo_q;
  logic [15:0] addr_mid_q;
  logic [15:0] addr_hi_q;
  logic [15:0] bus_ctrl_q;
  logic sw_access_q;
  logic [2:0] rom_pins_q;

  wire [15:0] err_wdata = half_data(OFS_BUS_ERR);
  wire flag_clear = lane_hit(OFS_BUS_ERR, 1'b1) & err_wdata[BIT_LANE_FLAG];
  wire [15:0] rom_wdata = half_data(OFS_ROM_CTRL);
  wire rom_ctrl_wr = lane_hit(OFS_ROM_CTRL, 1'b0);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lane_flag_q <= 1'b0;
      lane_pat_q <= 4'h0;
    end else begin
      // A new error in the clearing cycle wins over the clear.
      lane_flag_q <= bad_access | (lane_flag_q & ~flag_clear);
      if (bad_access) begin
        lane_pat_q <= i_bus_be;
      end
    end
  end

  // Address registers are plain storage; nothing written here goes back to the ROM.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      addr_lo_q <= ADDR_RST;
      addr_mid_q <= ADDR_RST;
      addr_hi_q <= ADDR_RST;
    end else begin
      addr_lo_q <= addr_lo_in ? ld_word : merge(addr_lo_q, OFS_ADDR_LO);
      addr_mid_q <= addr_mid_in ? ld_word : merge(addr_mid_q, OFS_ADDR_MID);
      addr_hi_q <= addr_hi_in ? ld_word : merge(addr_hi_q, OFS_ADDR_HI);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bus_ctrl_q <= BUS_CTRL_RST;
      sw_access_q <= 1'b0;
      rom_pins_q <= ROM_PINS_RST;
    end else begin
      bus_ctrl_q <= merge(bus_ctrl_q, OFS_BUS_CTRL);
      if (rom_ctrl_wr) begin
        sw_access_q <= rom_wdata[BIT_SW_ACCESS];
        rom_pins_q <= rom_wdata[BIT_PIN_DO:BIT_PIN_CS];
      end
    end
  end

  // Read path.
  wire [15:0] bus_err_val = {lane_flag_q, lane_pat_q, 11'h000};
  wire [15:0] chip_cfg_val = {5'h00, endian_q, present_q, 1'b0, byte_bus_q, half_bus_q,
                              BOND_WORD_BUS, 1'b0, BOND_PKG128, 3'h0};
  wire [15:0] rom_ctrl_val = {11'h000, sw_access_q, pin_q[PIN_DI], rom_pins_q};

  function automatic logic [15:0] rd_half(input logic [7:0] off);
    case (off)
      OFS_BUS_ERR: rd_half = bus_err_val;
      OFS_CHIP_CFG: rd_half = chip_cfg_val;
      OFS_ADDR_LO: rd_half = addr_lo_q;
      OFS_ADDR_MID: rd_half = addr_mid_q;
      OFS_ADDR_HI: rd_half = addr_hi_q;
      OFS_BUS_CTRL: rd_half = bus_ctrl_q;
      OFS_ROM_CTRL: rd_half = rom_ctrl_val;
      default: rd_half = 16'h0000;
    endcase
  endfunction : rd_half

  wire [31:0] rd_word = {rd_half({i_bus_addr[7:2], 2'h2}), rd_half({i_bus_addr[7:2], 2'h0})};

  // Serial pin ownership: software only after the reset-time load has finished.
  wire sw_active = sw_access_q & load_done_q;
  logic rdata_valid_q;
  logic [31:0] rdata_q;
  logic sk_out_q;
  logic sk_oe_q;
  logic do_out_q;
  logic cs_out_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
      rdata_valid_q <= 1'b0;
      sk_out_q <= 1'b0;
      sk_oe_q <= 1'b0;
      do_out_q <= 1'b0;
      cs_out_q <= 1'b0;
    end else begin
      rdata_valid_q <= rd_ok;
      if (rd_ok) begin
        rdata_q <= rd_word;
      end
      // The clock pin doubles as the endian strap, so it stays released until the strap is taken.
      sk_oe_q <= strap_done_q;
      cs_out_q <= sw_active ? rom_pins_q[BIT_PIN_CS] : ld_cs;
      sk_out_q <= sw_active ? rom_pins_q[BIT_PIN_SK] : ld_sk;
      do_out_q <= sw_active ? rom_pins_q[BIT_PIN_DO] : ld_do;
    end
  end

  assign o_bus_rdata = rdata_q;
  assign o_bus_rvalid = rdata_valid_q;
  assign o_rom_serial_clock_pin = sk_out_q;
  assign o_rom_serial_clock_oe = sk_oe_q;
  assign o_rom_data_output_pin = do_out_q;
  assign o_rom_chip_select_pin = cs_out_q;
  assign o_pad_drive_strong = bus_ctrl_q[BIT_DRIVE];
  assign o_bus_clk_sel = bus_ctrl_q[BIT_CLK_SEL];
  assign o_bus_clk_div = bus_ctrl_q[BIT_CLK_DIV_HI:0];
  assign o_config_loaded = load_done_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_bad_access;
    i_bus_sel && (i_bus_rd || i_bus_wr) && !lanes_legal;
  endsequence

  sequence seq_flag_clear_only;
    flag_clear && !bad_access;
  endsequence

  sequence seq_rom_ctrl_write;
    wr_ok && (i_bus_addr[7:2] == OFS_ROM_CTRL[7:2]) && i_bus_be[2];
  endsequence

  chk_flag_sets: assert property (seq_bad_access |=> lane_flag_q ##1 (lane_flag_q || $past(flag_clear)))
    else $error("lane flag did not set after a forbidden lane set");

  chk_flag_clears: assert property (seq_flag_clear_only |=> !lane_flag_q)
    else $error("lane flag did not clear on write of one");

  chk_flag_holds: assert property (lane_flag_q && !flag_clear |=> lane_flag_q)
    else $error("lane flag dropped without a clear");

  chk_pattern_capture: assert property (seq_bad_access |=> lane_pat_q == $past(i_bus_be))
    else $error("lane pattern not captured");

  chk_straps_frozen: assert property (strap_done_q |=> $stable(endian_q) && $stable(present_q))
    else $error("strap bits changed after capture");

  chk_strap_source: assert property (strap_take |=> endian_q == $past(pin_q[PIN_SK])
                                     && present_q == $past(pin_q[PIN_PRESENT]))
    else $error("strap bits not taken from pins");

  chk_width_no_rom: assert property (strap_take && !pin_q[PIN_PRESENT] |=>
                                     half_bus_q == $past(pin_q[PIN_DI]) && byte_bus_q != half_bus_q)
    else $error("bus width not taken from data-input strap");

  chk_cfg_readback: assert property (rd_ok && i_bus_addr[7:2] == OFS_CHIP_CFG[7:2] |=>
                                     o_bus_rdata[BIT_WORD_BUS] == BOND_WORD_BUS && o_bus_rdata[BIT_PKG128] == BOND_PKG128
                                     && o_bus_rvalid)
    else $error("chip configuration readback wrong");

  chk_addr_load: assert property (addr_lo_in |=> addr_lo_q == $past(ld_word))
    else $error("low station address not loaded from ROM word one");

  chk_drive_write: assert property (wr_ok && i_bus_addr[7:2] == OFS_BUS_CTRL[7:2] && i_bus_be[0] |=>
                                    o_pad_drive_strong == $past(i_bus_wdata[BIT_DRIVE])
                                    && o_bus_clk_div == $past(i_bus_wdata[BIT_CLK_DIV_HI:0]))
    else $error("bus control write did not reach the outputs");

  chk_sw_pins: assert property (seq_rom_ctrl_write ##1 sw_active |=> o_rom_chip_select_pin == $past(rom_pins_q[BIT_PIN_CS])
                                || $past(rom_ctrl_wr))
    else $error("software pin control not applied");

  chk_loader_owns: assert property (!sw_active |=> o_rom_chip_select_pin == $past(ld_cs)
                                    && o_rom_data_output_pin == $past(ld_do))
    else $error("loader lost the serial pins without software access");

  chk_di_live: assert property (rd_ok && i_bus_addr[7:2] == OFS_ROM_CTRL[7:2] |=>
                                o_bus_rdata[16 + BIT_ROM_DI] == $past(pin_q[PIN_DI]))
    else $error("data-input status not live");

endmodule : hostcfg_regs

/* File: verification/serial_rom_model.sv */
// Behavioural serial ROM that answers the read frames of the configuration loader.
`timescale 1ns/1ps
module serial_rom_model #(
  parameter logic [15:0] W0 = 16'h0002,
  parameter logic [15:0] W1 = 16'h89ab,
  parameter logic [15:0] W2 = 16'h4567,
  parameter logic [15:0] W3 = 16'h0123
) (
  // Serial pins
  input wire logic i_cs,
  input wire logic i_sk,
  input wire logic i_do,
  output logic o_di,
  // Frame statistics
  output logic [7:0] o_frames,
  output logic [7:0] o_bad
);
  logic [15:0] mem [4];
  logic [8:0] cmd;
  int n;
  initial begin
    mem = '{W0, W1, W2, W3};
    o_di = 1'b0;
    o_frames = 8'h00;
    o_bad = 8'h00;
    cmd = 9'h000;
    n = 0;
  end
  always @(posedge i_cs) n = 0;
  always @(posedge i_sk) begin
    if (i_cs) begin
      if (n < 9) cmd = {cmd[7:0], i_do};
      n++;
    end
  end
  // Data moves on the falling edge so it is long settled at the next rising edge.
  always @(negedge i_sk) begin
    if (i_cs && n >= 10 && n <= 25) o_di = mem[cmd[1:0]][25 - n];
  end
  // Once deselected the line floats; the inverse keeps a stale bit from passing as data.
  always @(negedge i_cs) begin
    if (cmd !== {3'b110, o_frames[5:0]}) o_bad++;
    o_frames++;
    o_di = ~o_di;
  end
endmodule : serial_rom_model

/* File: verification/hostcfg_regs_tb_top.sv */
// Self-checking bench for the host configuration register bank.
`timescale 1ns/1ps
module hostcfg_regs_tb_top;
  import hostcfg_pkg::*;
  logic mclk, rst_n, sel, rd, wr, present, endian, strap_di;
  logic rvalid, sk, sk_oe, dout, cs, pad, csel, loaded, model_di;
  logic [7:0] addr, frames, bad;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  logic [1:0] div;
  logic [15:0] h;
  // Clock source one and divider code three are reserved, so software never writes them.
  logic [15:0] internal_bus_control [4] = '{16'h0041, 16'h0001, 16'hff82, 16'h0000};
  logic [3:0] bad_be [9] = '{4'h5, 4'h6, 4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'h7, 4'h0};
  int n_errors = 0;
  int compares = 0;
  int i;
  // The clock pin doubles as the endian strap while the design leaves it released.
  wire logic sk_w = sk_oe ? sk : endian;
  wire logic di_w = present ? model_di : strap_di;
  wire logic model_cs = cs & present;

  hostcfg_regs hostcfg_regs_i (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_bus_sel(sel), .i_bus_rd(rd), .i_bus_wr(wr),
    .i_bus_addr(addr), .i_bus_be(be), .i_bus_wdata(wdata), .o_bus_rdata(rdata), .o_bus_rvalid(rvalid),
    .i_rom_present_strap(present), .i_rom_data_input_pin(di_w), .i_rom_serial_clock_pin(sk_w),
    .o_rom_serial_clock_pin(sk), .o_rom_serial_clock_oe(sk_oe), .o_rom_data_output_pin(dout),
    .o_rom_chip_select_pin(cs), .o_pad_drive_strong(pad), .o_bus_clk_sel(csel), .o_bus_clk_div(div),
    .o_config_loaded(loaded)
  );
  serial_rom_model serial_rom_model_i (
    .i_cs(model_cs), .i_sk(sk_w), .i_do(dout), .o_di(model_di), .o_frames(frames), .o_bad(bad)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [15:0] d);
    @(negedge mclk);
    sel = 1'b1; rd = !w; wr = w; addr = a; be = b; wdata = {d, d};
    @(negedge mclk);
    sel = 1'b0; rd = 1'b0; wr = 1'b0;
    h = a[1] ? rdata[31:16] : rdata[15:0];
    if (!w) chk({31'h0, rvalid}, 32'h1);
  endtask : acc

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, a[1] ? 4'hc : 4'h3, d);
  endtask : wr16

  task automatic rd16(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    acc(1'b0, a, a[1] ? 4'hc : 4'h3, 16'h0000);
    chk({16'h0, h & m}, {16'h0, e});
  endtask : rd16

  task automatic pins(input logic [2:0] v);
    @(negedge mclk);
    chk({29'h0, dout, sk, cs}, {29'h0, v});
  endtask : pins

  task automatic boot(input logic p, input logic e, input logic s);
    @(negedge mclk);
    present = p; endian = e; strap_di = s; rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    // Software asks for the pins at once; they must stay with the loader until it ends.
    wr16(OFS_ROM_CTRL, 16'h0017);
    i = 0;
    while (loaded !== 1'b1 && i < 6000) begin
      @(negedge mclk);
      i++;
    end
    chk({31'h0, loaded}, 32'h1);
    pins(3'h7);
  endtask : boot

  task automatic complete_run;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12000) @(posedge mclk);
    n_errors++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0; sel = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h00; be = 4'h0; wdata = 32'h0;
    present = 1'b0; endian = 1'b1; strap_di = 1'b0;
    boot(1'b0, 1'b1, 1'b0);
    rd16(OFS_CHIP_CFG, 16'h07ff, 16'h04a8);
    rd16(OFS_BUS_CTRL, 16'hffff, 16'h0000);
    rd16(8'h18, 16'hffff, 16'h0000);
    $display("straps without rom done");
    for (int k = 0; k < 8; k++) begin
      strap_di = k[0];
      wr16(OFS_ROM_CTRL, 16'h0010 | 16'(k));
      pins(k[2:0]);
      rd16(OFS_ROM_CTRL, 16'h001f, 16'h0010 | 16'(k) | {12'h0, k[0], 3'h0});
    end
    wr16(OFS_ROM_CTRL, 16'h0005);
    pins(3'h0);
    rd16(OFS_ROM_CTRL, 16'h0017, 16'h0005);
    $display("software pins done");
    foreach (internal_bus_control[k]) begin
      wr16(OFS_BUS_CTRL, internal_bus_control[k]);
      chk({28'h0, pad, csel, div}, {28'h0, internal_bus_control[k][6], internal_bus_control[k][2], internal_bus_control[k][1:0]});
      rd16(OFS_BUS_CTRL, 16'hffff, internal_bus_control[k]);
    end
    $display("bus control done");
    wr16(OFS_ADDR_LO, 16'h1111);
    wr16(OFS_ADDR_MID, 16'h2222);
    wr16(OFS_ADDR_HI, 16'h3333);
    rd16(OFS_ADDR_MID, 16'hffff, 16'h2222);
    rd16(OFS_ADDR_HI, 16'hffff, 16'h3333);
    foreach (bad_be[k]) begin
      acc(1'b1, OFS_ADDR_LO, bad_be[k], 16'hdead);
      rd16(OFS_BUS_ERR, 16'hf800, {1'b1, bad_be[k], 11'h0});
    end
    rd16(OFS_ADDR_LO, 16'hffff, 16'h1111);
    wr16(OFS_BUS_ERR, 16'h8000);
    rd16(OFS_BUS_ERR, 16'h8000, 16'h0000);
    $display("lane errors done");
    boot(1'b1, 1'b0, 1'b1);
    chk({24'h0, frames}, 32'h4);
    chk({24'h0, bad}, 32'h0);
    rd16(OFS_CHIP_CFG, 16'h07ff, 16'h0268);
    rd16(OFS_ADDR_LO, 16'hffff, 16'h89ab);
    rd16(OFS_ADDR_MID, 16'hffff, 16'h4567);
    rd16(OFS_ADDR_HI, 16'hffff, 16'h0123);
    wr16(OFS_ADDR_HI, 16'h0a0b);
    rd16(OFS_ADDR_HI, 16'hffff, 16'h0a0b);
    pins(3'h7);
    chk({24'h0, frames}, 32'h4);
    $display("rom load done");
    complete_run();
  end
endmodule : hostcfg_regs_tb_top
